// File: shared/tracker_pkg.sv
// Purpose: Shared constants and types for the engine angle tracker.
// Assumes: APB with 32-bit data; pclk at 20 MHz.
// Notes:   Offsets are byte addresses of aligned words.
package tracker_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WHEEL  = 8'h04;
    localparam logic [7:0] OFS_STALL  = 8'h08;
    localparam logic [7:0] OFS_FILTER = 8'h0c;
    localparam logic [7:0] OFS_SIM    = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TOOTH  = 8'h18;
    localparam logic [7:0] OFS_ANGLE  = 8'h1c;
    localparam logic [7:0] OFS_DEGREE = 8'h20;
    localparam logic [7:0] OFS_LIMIT  = 8'h24;
    localparam logic [7:0] OFS_PERIOD = 8'h28;

    // Control and wheel register bit positions.
    localparam int CTRL_LOCK_EN  = 0;
    localparam int CTRL_SIM_EN   = 1;
    localparam int CTRL_FOUR_STK = 2;
    localparam int CTRL_VAR_LSB  = 4;
    localparam int CTRL_FLT_CLR  = 8;
    localparam int WHEEL_GAP_LSB = 16;

    // Tooth period timer runs at 40 MHz; pclk is 20 MHz, so it steps by two.
    localparam int TIMER_HZ = 40_000_000;
    localparam int PCLK_HZ  = 20_000_000;
    localparam logic [23:0] TIMER_STEP = 24'(TIMER_HZ / PCLK_HZ);

    localparam logic [1:0]  STROKE_FOUR  = 2'h2;
    localparam logic [1:0]  STROKE_TWO   = 2'h1;
    localparam logic [9:0]  DEG_PER_REV  = 10'h168;
    localparam logic [4:0]  DIV_STEPS    = 5'h1a;

    // Extrapolation bits per variant.
    localparam logic [3:0] XB_ENC2 = 4'h2;
    localparam logic [3:0] XB_ENC4 = 4'h4;
    localparam logic [3:0] XB_GAP  = 4'h7;
    localparam logic [3:0] XB_PLUS = 4'h9;

    typedef enum logic [1:0] {
        VAR_ENC2 = 2'b00,
        VAR_ENC4 = 2'b01,
        VAR_GAP  = 2'b10,
        VAR_PLUS = 2'b11
    } tracker_variant_type;

    typedef enum logic [1:0] {
        ST_STOPPED = 2'b00,
        ST_COUNT   = 2'b01,
        ST_SEARCH  = 2'b10,
        ST_SYNC    = 2'b11
    } lock_state_type;

endpackage

// File: design/input_filter.sv
// Purpose: Persistence glitch filter for one synchronised pulse input.
// Assumes: The input is already in the pclk domain.
// Notes:   A level must persist filter_time + 1 cycles before the output follows.
`timescale 1ns/1ns
module input_filter
    import tracker_pkg::*;
#(
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Pulse path
    input  wire logic          raw,
    input  wire logic [CW-1:0] filter_time,
    output logic               filt
);
    logic [CW-1:0] run;

    wire differs = raw != filt;
    wire settled = differs && (run >= filter_time);

    // Any return to the old level restarts the count, so short pulses of
    // either polarity never reach the output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run  <= '0;
            filt <= 1'b0;
        end else begin
            run  <= (differs && !settled) ? run + 1'b1 : '0;
            filt <= settled ? raw : filt;
        end
    end
endmodule // input_filter

// File: design/angle_tracker.sv
// Purpose: Engine angle tracker with APB registers, filters and simulator.
// Assumes: 20 MHz pclk; crank and cam pins are asynchronous.
// Notes:   Pattern checks are generic per variant; cam phasing is not checked.
`timescale 1ns/1ns
module angle_tracker
    import tracker_pkg::*;
#(
    parameter int FW = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Sensor pins
    input  wire logic        crank_pin,
    input  wire logic        cam_pulse_input,
    // Status
    output logic             shaft_motion_flag,
    output logic             lock_state_flag
);
    // Configuration registers.
    logic                position_lock_enable;
    logic                pattern_sim_enable;
    logic                four_stroke;
    tracker_variant_type tracker_variant;
    logic [11:0]         wheel_tooth_total;
    logic [1:0]          gap_tooth_total;
    logic [23:0]         stall_period;
    logic [FW-1:0]       filter_time;
    logic [23:0]         sim_rpm_setting;

    // Tracking state.
    lock_state_type      state;
    logic                lock_fault;
    logic [12:0]         cycle_cnt;
    logic [12:0]         rev_tooth;
    logic [12:0]         tooth_index;
    logic [23:0]         per_cnt;
    logic [23:0]         last_period;
    logic [23:0]         acc;
    logic [15:0]         angle_ticks_now;
    logic [15:0]         tooth_pos;
    logic [9:0]          crank_degree;
    logic [1:0]          pin_s1;
    logic [1:0]          pin_s2;
    logic [1:0]          filt;
    logic [1:0]          filt_d;
    logic                cam_seen;

    // APB decode.
    wire wr_en     = psel && penable && pwrite;
    wire hit_ctrl  = paddr == OFS_CTRL;
    wire hit_wheel = paddr == OFS_WHEEL;
    wire hit_stall = paddr == OFS_STALL;
    wire hit_filt  = paddr == OFS_FILTER;
    wire hit_sim   = paddr == OFS_SIM;
    wire hit_any   = hit_ctrl || hit_wheel || hit_stall || hit_filt || hit_sim
                   || paddr == OFS_STATUS || paddr == OFS_TOOTH
                   || paddr == OFS_ANGLE || paddr == OFS_DEGREE
                   || paddr == OFS_LIMIT || paddr == OFS_PERIOD;
    wire fault_clear = wr_en && hit_ctrl && pwdata[CTRL_FLT_CLR];
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Variant derived values.
    wire [3:0] xbits = (tracker_variant == VAR_ENC2) ? XB_ENC2 :
                       (tracker_variant == VAR_ENC4) ? XB_ENC4 :
                       (tracker_variant == VAR_GAP)  ? XB_GAP : XB_PLUS;
    wire [16:0] tpt         = 17'h1 << xbits;
    wire [12:0] cycle_teeth = four_stroke ? {wheel_tooth_total, 1'b0}
                                          : {1'b0, wheel_tooth_total};
    wire [15:0] cycle_tick_limit = 16'(cycle_teeth << xbits);
    wire [12:0] phys_rev    = (tracker_variant == VAR_GAP)
                            ? 13'(wheel_tooth_total - 12'(gap_tooth_total)) :
                              (tracker_variant == VAR_PLUS)
                            ? 13'(wheel_tooth_total + 12'h1) : cycle_teeth;
    wire [12:0] phys_cycle  = (four_stroke && tracker_variant[1])
                            ? 13'(phys_rev << 1) : phys_rev;

    // Simulator.
    logic [23:0] sim_cnt;
    logic [11:0] sim_tooth;
    logic        sim_rev;
    wire sim_wrap   = sim_cnt >= sim_rpm_setting - 24'h1;
    wire sim_last   = sim_tooth >= wheel_tooth_total - 12'h1;
    wire sim_gap    = (tracker_variant == VAR_GAP)
                    && (sim_tooth >= wheel_tooth_total - 12'(gap_tooth_total));
    wire sim_crank  = (sim_cnt < (sim_rpm_setting >> 1)) && !sim_gap;
    wire sim_cam    = (sim_tooth == 12'h0) && (sim_rev || !four_stroke);
    wire [1:0] raw  = pattern_sim_enable ? {sim_cam, sim_crank} : pin_s2;

    // Tooth events and features.
    wire tooth_ev   = filt[0] && !filt_d[0];
    wire cam_ev     = filt[1] && !filt_d[1];
    wire stalled    = per_cnt > stall_period;
    wire spin_ok    = position_lock_enable && !lock_fault
                    && (stall_period != 24'h0) && (wheel_tooth_total != 12'h0);
    wire feature    = (tracker_variant == VAR_GAP)
                    ? per_cnt > last_period + (last_period >> 1) :
                      (tracker_variant == VAR_PLUS)
                    ? per_cnt < (last_period >> 1) : (cam_seen || cam_ev);
    wire feature_due = rev_tooth >= phys_rev - 13'h1;
    wire pattern_err = feature != feature_due;
    wire [12:0] skip = (tracker_variant == VAR_GAP) ? 13'(gap_tooth_total) + 13'h1 :
                       (tracker_variant == VAR_PLUS) ? 13'h0 : 13'h1;
    wire [12:0] idx_step = feature ? skip : 13'h1;
    wire [13:0] idx_sum  = 14'(tooth_index) + 14'(idx_step);
    wire [12:0] idx_next = (idx_sum >= 14'(cycle_teeth))
                         ? 13'(idx_sum - 14'(cycle_teeth)) : 13'(idx_sum);
    wire [15:0] pos_next = 16'(idx_next << xbits);

    // Extrapolation.
    wire [16:0] hold_pos = 17'(tooth_pos) + tpt;
    wire        lagging  = angle_ticks_now < tooth_pos;
    wire        at_hold  = 17'(angle_ticks_now) >= hold_pos;
    wire [23:0] acc_sum  = acc + 24'(tpt) * TIMER_STEP;
    wire        rate_hit = acc_sum >= last_period;

    // Pin synchronisers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            filt_d <= 2'h0;
        end else begin
            pin_s1 <= {cam_pulse_input, crank_pin};
            pin_s2 <= pin_s1;
            filt_d <= filt;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_filt
            input_filter #(.CW(FW)) u_filt (
                .pclk        (pclk),
                .presetn     (presetn),
                .raw         (raw[ch]),
                .filter_time (filter_time),
                .filt        (filt[ch])
            );
        end
    endgenerate

    // Register writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_lock_enable <= 1'b0;
            pattern_sim_enable   <= 1'b0;
            four_stroke          <= 1'b0;
            tracker_variant      <= VAR_GAP;
            wheel_tooth_total    <= 12'h0;
            gap_tooth_total      <= 2'h0;
            stall_period         <= 24'h0;
            filter_time          <= '0;
            sim_rpm_setting      <= 24'h0;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                position_lock_enable <= pwdata[CTRL_LOCK_EN];
                pattern_sim_enable   <= pwdata[CTRL_SIM_EN];
                four_stroke          <= pwdata[CTRL_FOUR_STK];
                tracker_variant      <= tracker_variant_type'(pwdata[CTRL_VAR_LSB +: 2]);
            end
            if (hit_wheel) begin
                wheel_tooth_total <= pwdata[11:0];
                gap_tooth_total   <= pwdata[WHEEL_GAP_LSB +: 2];
            end
            if (hit_stall) stall_period <= pwdata[23:0];
            if (hit_filt) filter_time <= pwdata[FW-1:0];
            if (hit_sim) sim_rpm_setting <= pwdata[23:0];
        end
    end

    // Read data is captured in the setup phase and stands through access.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (paddr)
            OFS_CTRL:   rd_mux = {28'h0, 2'(tracker_variant), 1'b0, four_stroke} << 2
                               | {30'h0, pattern_sim_enable, position_lock_enable};
            OFS_WHEEL:  rd_mux = {14'h0, gap_tooth_total, 4'h0, wheel_tooth_total};
            OFS_STALL:  rd_mux = {8'h0, stall_period};
            OFS_FILTER: rd_mux = 32'(filter_time);
            OFS_SIM:    rd_mux = {8'h0, sim_rpm_setting};
            OFS_STATUS: rd_mux = {29'h0, lock_fault, lock_state_flag, shaft_motion_flag};
            OFS_TOOTH:  rd_mux = {19'h0, tooth_index};
            OFS_ANGLE:  rd_mux = {16'h0, angle_ticks_now};
            OFS_DEGREE: rd_mux = {22'h0, crank_degree};
            OFS_LIMIT:  rd_mux = {16'h0, cycle_tick_limit};
            OFS_PERIOD: rd_mux = {8'h0, last_period};
            default:    rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (psel && !penable) prdata <= rd_mux;
    end

    // Pattern simulator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sim_cnt   <= 24'h0;
            sim_tooth <= 12'h0;
            sim_rev   <= 1'b0;
        end else if (!pattern_sim_enable) begin
            sim_cnt   <= 24'h0;
            sim_tooth <= 12'h0;
            sim_rev   <= 1'b0;
        end else begin
            sim_cnt   <= sim_wrap ? 24'h0 : sim_cnt + 24'h1;
            sim_tooth <= !sim_wrap ? sim_tooth : sim_last ? 12'h0 : sim_tooth + 12'h1;
            sim_rev   <= sim_rev ^ (sim_wrap && sim_last);
        end
    end

    // Tooth period timer, saturating at 24'hfffffe, one count below its 24-bit top.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt     <= 24'h0;
            last_period <= 24'hffffff;
            cam_seen    <= 1'b0;
        end else begin
            if (tooth_ev) per_cnt <= TIMER_STEP;
            else if (per_cnt <= 24'hffffff - TIMER_STEP) per_cnt <= per_cnt + TIMER_STEP;
            if (tooth_ev) last_period <= per_cnt;
            cam_seen <= tooth_ev ? 1'b0 : (cam_seen || cam_ev);
        end
    end

    // Lock sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= ST_STOPPED;
            lock_fault        <= 1'b0;
            cycle_cnt         <= 13'h0;
            rev_tooth         <= 13'h0;
            tooth_index       <= 13'h0;
            shaft_motion_flag <= 1'b0;
        end else begin
            if (stalled) shaft_motion_flag <= 1'b0;
            else if (tooth_ev) shaft_motion_flag <= 1'b1;
            if (state == ST_SYNC && tooth_ev && pattern_err) lock_fault <= 1'b1;
            else if (fault_clear) lock_fault <= 1'b0;
            if (!spin_ok || stalled) begin
                state       <= ST_STOPPED;
                tooth_index <= 13'h0;
            end else if (tooth_ev) begin
                case (state)
                    ST_STOPPED: begin
                        state     <= ST_COUNT;
                        cycle_cnt <= 13'h0;
                    end
                    ST_COUNT: begin
                        cycle_cnt <= cycle_cnt + 13'h1;
                        if (cycle_cnt >= phys_cycle - 13'h1) state <= ST_SEARCH;
                    end
                    ST_SEARCH: begin
                        if (feature) begin
                            state       <= ST_SYNC;
                            tooth_index <= 13'h0;
                            rev_tooth   <= 13'h0;
                        end
                    end
                    ST_SYNC: begin
                        if (pattern_err) begin
                            state       <= ST_STOPPED;
                            tooth_index <= 13'h0;
                        end else begin
                            tooth_index <= idx_next;
                            rev_tooth   <= feature ? 13'h0 : rev_tooth + 13'h1;
                        end
                    end
                    default: state <= ST_STOPPED;
                endcase
            end
        end
    end

    assign lock_state_flag = state == ST_SYNC;

    // Angle extrapolation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_ticks_now <= 16'h0;
            tooth_pos       <= 16'h0;
            acc             <= 24'h0;
        end else if (state != ST_SYNC) begin
            angle_ticks_now <= 16'h0;
            tooth_pos       <= 16'h0;
            acc             <= 24'h0;
        end else if (tooth_ev) begin
            tooth_pos <= pos_next;
            acc       <= 24'h0;
            if (idx_next == 13'h0) angle_ticks_now <= 16'h0;
        end else if (lagging) begin
            angle_ticks_now <= angle_ticks_now + 16'h1;
        end else if (!at_hold) begin
            acc <= rate_hit ? acc_sum - last_period : acc_sum;
            if (rate_hit) angle_ticks_now <= angle_ticks_now + 16'h1;
        end
        // Holding at the next tooth's position is the absence of an update.
    end

    // Degree conversion by a restoring divider, one quotient bit per cycle.
    logic [4:0]  div_cnt;
    logic [25:0] div_num;
    logic [16:0] div_rem;
    wire  [1:0]  stroke_factor = four_stroke ? STROKE_FOUR : STROKE_TWO;
    wire  [25:0] deg_num = 26'(angle_ticks_now * DEG_PER_REV * stroke_factor);
    wire  [16:0] trial   = {div_rem[15:0], div_num[25]};
    wire         fits    = trial >= 17'(cycle_tick_limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt      <= 5'h0;
            div_num      <= 26'h0;
            div_rem      <= 17'h0;
            crank_degree <= 10'h0;
        end else if (div_cnt == 5'h0) begin
            crank_degree <= div_num[9:0];
            div_num      <= deg_num;
            div_rem      <= 17'h0;
            div_cnt      <= DIV_STEPS;
        end else begin
            div_rem <= fits ? trial - 17'(cycle_tick_limit) : trial;
            div_num <= {div_num[24:0], fits};
            div_cnt <= div_cnt - 5'h1;
        end
    end
endmodule // angle_tracker

// File: testbench/angle_tracker_props.sv
// Purpose: Port-level checker for the angle tracker.
// Assumes: Zero-wait APB slave; status flags are levels.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ns
module angle_tracker_props
    import tracker_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Status
    input wire logic        shaft_motion_flag,
    input wire logic        lock_state_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd(logic [7:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence

    a_ready_zero: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (psel && penable && paddr > OFS_PERIOD |-> pslverr)
        else $error("unmapped access without error");
    a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > OFS_PERIOD |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_mapped_clean: assert property (psel && penable && paddr <= OFS_PERIOD && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged");
    a_clear_self: assert property (s_rd(OFS_CTRL) |-> !prdata[CTRL_FLT_CLR])
        else $error("fault clear bit reads back set");
    a_status_mirror: assert property (s_rd(OFS_STATUS) |-> prdata[1:0] == {$past(lock_state_flag), $past(shaft_motion_flag)})
        else $error("status bits differ from flags");
    a_lock_after_spin: assert property ($rose(lock_state_flag) |-> shaft_motion_flag)
        else $error("lock without spinning");
    a_enable_drop: assert property (psel && penable && pwrite && paddr == OFS_CTRL && !pwdata[CTRL_LOCK_EN] |-> ##2 !lock_state_flag [*3])
        else $error("lock kept after enable off");
    a_stop_index: assert property (s_rd(OFS_TOOTH) ##0 !$past(shaft_motion_flag) |-> prdata == 32'h0)
        else $error("tooth index nonzero while stopped");
    a_period_width: assert property (s_rd(OFS_PERIOD) |-> prdata[31:24] == 8'h00)
        else $error("tooth period wider than 24 bits");
endmodule // angle_tracker_props

// File: testbench/wheel_sensor_model.sv
// Purpose: Crank and cam sensor model: a 12-2 wheel, 40 pclk per tooth slot.
// Assumes: Slots 10 and 11 form the gap; the cam marks slot 0.
// Notes:   Glitches are two cycles of either polarity, shorter than any filter we set.
`timescale 1ns/1ns
module wheel_sensor_model (
    // Clock
    input  wire logic pclk,
    // Stimulus controls
    input  wire logic run,
    input  wire logic glitch,
    input  wire logic drop,
    // Sensor lines
    output logic      crank,
    output logic      cam
);
    int ph    = 0;
    int tooth = 0;

    // A steady 40-cycle slot keeps the tooth period well under the stall period.
    always @(posedge pclk) begin
        if (run) begin
            ph <= (ph == 39) ? 0 : ph + 1;
            if (ph == 39) begin
                tooth <= (tooth == 11) ? 0 : tooth + 1;
            end
        end
    end
    // The single wheel drives the crank line; dropping slot 5 fakes a missing tooth.
    assign crank = run && ((tooth < 10 && !(drop && tooth == 5) && ph < 20
        && !(glitch && ph inside {[8:9]})) || (glitch && ph inside {[30:31]}));
    assign cam = run && tooth == 0 && ph < 20;
endmodule // wheel_sensor_model

// File: testbench/test_angle_tracker.sv
// Purpose: Self-checking bench for the angle tracker.
// Assumes: 20 MHz pclk; the sensor model runs a 12-2 wheel.
// Notes:   Stall and filter figures are small so each scenario stays short.
`timescale 1ns/1ns
module test_angle_tracker
    import tracker_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, crank_pin, cam_pulse_input, e;
    logic        shaft_motion_flag, lock_state_flag;
    logic        run = 1'b0, glitch = 1'b0, drop = 1'b0;
    int          fail_count = 0;
    int          samples_checked = 0;

    always #25 pclk = ~pclk;

    angle_tracker #(.FW(16)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crank_pin(crank_pin), .cam_pulse_input(cam_pulse_input),
        .shaft_motion_flag(shaft_motion_flag), .lock_state_flag(lock_state_flag));
    wheel_sensor_model i_wheel (.pclk(pclk), .run(run), .glitch(glitch), .drop(drop),
        .crank(crank_pin), .cam(cam_pulse_input));

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Entered just after a rising edge; the idle edge at the end keeps strobes single-driven.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            check("pready wait", 32'h1, 32'h0);
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_for(input logic m, input logic want, input int lim);
        int n;
        n = 0;
        while ((m ? shaft_motion_flag : lock_state_flag) !== want && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            check(m ? "motion wait" : "lock wait", 32'(want), 32'(~want));
            conclude();
        end
    endtask

    task automatic t_reset();
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", 32'h20, r);
        apb(1'b0, OFS_PERIOD, 32'h0);
        check("period reset", 32'h00ffffff, r);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, OFS_STATUS, 32'h7);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status read only", 32'h0, r);
    endtask

    task automatic t_limit();
        int xb[4] = '{2, 4, 7, 9};
        apb(1'b1, OFS_WHEEL, 32'd12);
        for (int v = 0; v < 4; v++) begin
            for (int s = 1; s <= 2; s++) begin
                apb(1'b1, OFS_CTRL, 32'((v << 4) | ((s - 1) << 2)));
                apb(1'b0, OFS_LIMIT, 32'h0);
                check("cycle limit", 32'(s * 12 * (1 << xb[v])), r);
            end
        end
    endtask

    task automatic t_lock();
        apb(1'b1, OFS_WHEEL, 32'h0002000c);
        apb(1'b1, OFS_STALL, 32'd400);
        apb(1'b1, OFS_FILTER, 32'd5);
        apb(1'b1, OFS_CTRL, 32'h21);
        glitch <= 1'b1;
        run    <= 1'b1;
        wait_for(1'b1, 1'b1, 2000);
        check("lock at spin", 32'h0, {31'h0, lock_state_flag});
        wait_for(1'b0, 1'b1, 3000);
        apb(1'b0, OFS_TOOTH, 32'h0);
        check("tooth range", 32'h1, 32'(r < 32'd12));
        apb(1'b0, OFS_DEGREE, 32'h0);
        check("degree range", 32'h1, 32'(r < 32'd360));
        apb(1'b0, OFS_PERIOD, 32'h0);
        check("tooth period", 32'h1, 32'(r == 32'd80 || r == 32'd240));
    endtask

    task automatic t_stall();
        logic [31:0] a0;
        // Stopping just after tooth zero leaves the angle one tooth to climb at a tick per
        // cycle, so it settles at its hold point well before the stall timer runs out.
        for (int n = 0; n < 600 && !(i_wheel.tooth == 0 && i_wheel.ph == 25); n++)
            @(posedge pclk);
        if (!(i_wheel.tooth == 0 && i_wheel.ph == 25)) begin
            check("stop point wait", 32'h1, 32'h0);
            conclude();
        end
        run <= 1'b0;
        repeat (140) @(posedge pclk);
        apb(1'b0, OFS_ANGLE, 32'h0);
        a0 = r;
        check("angle hold point", 32'(1 << XB_GAP), a0);
        apb(1'b0, OFS_ANGLE, 32'h0);
        check("angle hold", a0, r);
        wait_for(1'b0, 1'b0, 400);
        check("motion stalled", 32'h0, {31'h0, shaft_motion_flag});
        apb(1'b0, OFS_TOOTH, 32'h0);
        check("tooth stopped", 32'h0, r);
    endtask

    task automatic t_fault();
        logic seen;
        seen = 1'b0;
        run <= 1'b1;
        wait_for(1'b0, 1'b1, 3000);
        drop <= 1'b1;
        wait_for(1'b0, 1'b0, 1000);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("fault status", 32'h4, r & 32'h6);
        drop <= 1'b0;
        repeat (1500) begin
            @(posedge pclk);
            seen = seen | lock_state_flag;
        end
        check("relock blocked", 32'h0, {31'h0, seen});
        apb(1'b1, OFS_CTRL, 32'h121);
        wait_for(1'b0, 1'b1, 3000);
    endtask

    task automatic t_sim();
        run <= 1'b0;
        wait_for(1'b0, 1'b0, 600);
        apb(1'b1, OFS_SIM, 32'd40);
        apb(1'b1, OFS_CTRL, 32'h23);
        wait_for(1'b0, 1'b1, 4000);
        apb(1'b1, OFS_CTRL, 32'h20);
        wait_for(1'b0, 1'b0, 8);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_limit();
        t_lock();
        t_stall();
        t_fault();
        t_sim();
        conclude();
    end
endmodule // test_angle_tracker

bind angle_tracker angle_tracker_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shaft_motion_flag(shaft_motion_flag), .lock_state_flag(lock_state_flag));
